// ===== logic/rsc_params.svh
// Constants for the reset and stop release controller.
`ifndef RSC_PARAMS_SVH
`define RSC_PARAMS_SVH

// ********************************************************************
// Timing
// ********************************************************************
// Stopped-clock interval after release, in slow oscillator periods.
`define RSC_STOP_CLK_PERIODS   21
// Least external reset pulse width, in microseconds.
`define RSC_MIN_PIN_US         10
// System clock frequency in MHz.
`define RSC_CLOCK_MHZ          25
// Least pin pulse in clock cycles, rounded up.
`define RSC_MIN_PIN_CYCLES     (`RSC_MIN_PIN_US * `RSC_CLOCK_MHZ)
// Default oscillation stabilization count, in slow oscillator periods.
`define RSC_OSC_WAIT_DEFAULT   64

// ********************************************************************
// Reset values and addresses
// ********************************************************************
`define RSC_RESET_VECTOR_LO    16'h0000
`define RSC_RESET_VECTOR_HI    16'h0001
`define RSC_WAIT_SELECT_RESET  8'h05
`define RSC_WAIT_STATUS_RESET  8'h00
`define RSC_CAUSE_RESET        8'h00
// Bit positions within the reset cause flags.
`define RSC_CAUSE_WDOG_BIT     4
`define RSC_CAUSE_SUPPLY_BIT   0

`endif

// ===== logic/rsc_pkg.sv
// Types shared by the reset and stop release controller.
package rsc_pkg;

  // ******************************************************************
  // Sequencer states
  // ******************************************************************
  typedef enum logic [2:0] {
    RSC_HOLD,
    RSC_STOPPED_CLOCK,
    RSC_FETCH_LO,
    RSC_FETCH_HI,
    RSC_RUN,
    RSC_STOP_MODE,
    RSC_OSC_WAIT
  } rsc_state_e;

  // What the CPU does after the stop mode is left.
  typedef enum logic [1:0] {
    RSC_RESUME_NONE,
    RSC_RESUME_SERVICE,
    RSC_RESUME_NEXT
  } rsc_resume_e;

endpackage

// ===== logic/rsc_sync.sv
// Reset release synchroniser on the slow oscillator tick.
module rsc_sync (
  input  wire logic CLOCK,
  input  wire logic RST,
  input  wire logic reset_any,
  input  wire logic slow_tick,
  output logic      reset_sync
);

  logic stage1;

  // Assertion is immediate; release waits two slow ticks.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      stage1     <= 1'b1;
      reset_sync <= 1'b1;
    end else if (reset_any) begin
      stage1     <= 1'b1;
      reset_sync <= 1'b1;
    end else if (slow_tick) begin
      stage1     <= 1'b0;
      reset_sync <= stage1;
    end
  end

endmodule

// ===== logic/rsc_reset_control.sv
// Reset merging, release sequencing and stop mode release decisions.
//
// Overview of operation
// R01 - Masked request keeps stop; pin always resets.
// R02 - Unmasked request leaves stop; service or continue.
// R03 - Four reset sources are accepted.
// R04 - Same effect; vector fetched from 0000H, 0001H.
// R05 - Low pin, overflow or detector asserts reset.
// R06 - Ports high impedance during reset and wait.
// R07 - Pin release: clock stopped 21 slow periods.
// R08 - Watchdog reset self releases, same interval.
// R09 - Detector reset releases when supply recovers.
// R10 - External party holds pin low 10 us.
// R11 - Pin reset stops crystal and slow clocks.
// R12 - Stop contents kept during reset; ports float.
// R13 - Supply drop reset spares its own detector.
// R14 - Watchdog reset also resets the watchdog.
// R15 - Wait select initialises to 05H.
// R16 - Wait status initialises to 00H.
// R17 - Stabilization wait precedes service after stop.
// R18 - Cause flags: watchdog, supply; cleared by pin/POWER_ON_CLEAR_DETECTOR/read.
// R19 - Merged reset release synchronised to slow clock.
// R20 - Each source held until its own release.
`include "rsc_params.svh"

module rsc_reset_control #(
  parameter int STOP_PERIODS = `RSC_STOP_CLK_PERIODS,
  parameter int OSC_WAIT     = `RSC_OSC_WAIT_DEFAULT
) (
  input  wire logic        CLOCK,
  input  wire logic        RST,
  input  wire logic        SLOW_TICK,
  input  wire logic        RESET_PIN_N,
  input  wire logic        WATCHDOG_OVERFLOW,
  input  wire logic        POWER_ON_CLEAR_DETECT,
  input  wire logic        SUPPLY_DROP_DETECT,
  input  wire logic        STOP_ENTER,
  input  wire logic        INTERRUPT_REQUEST,
  input  wire logic        INTERRUPT_MASK_FLAG,
  input  wire logic        INTERRUPT_PRIORITY_FLAG,
  input  wire logic        INTERRUPT_ENABLE_FLAG,
  input  wire logic        IN_SERVICE_PRIORITY_FLAG,
  input  wire logic        CAUSE_READ,
  input  wire logic [7:0]  WAIT_SELECT_WRITE_DATA,
  input  wire logic        WAIT_SELECT_WRITE,
  output logic             CPU_RESET,
  output logic             CPU_CLOCK_ENABLE,
  output logic             CLOCKS_STOPPED,
  output logic             PORTS_HIGH_Z,
  output logic             WATCHDOG_RESET,
  output logic             SUPPLY_DETECTOR_RESET,
  output logic             STOP_CONTEXT_CLEAR,
  output logic [15:0]      VECTOR_ADDRESS,
  output logic             VECTOR_READ,
  output logic             PC_LOAD_LO,
  output logic             PC_LOAD_HI,
  output logic             IN_STOP,
  output logic             RESUME_SERVICE,
  output logic             RESUME_NEXT,
  output logic [7:0]       OSCILLATION_WAIT_SELECT,
  output logic [7:0]       OSCILLATION_WAIT_STATUS,
  output logic [7:0]       RESET_CAUSE_FLAGS
);

  // ******************************************************************
  // Merged reset and hold of each source
  // ******************************************************************
  logic                 pin_hold;
  logic                 wdog_hold;
  logic                 reset_any;
  logic                 reset_sync;
  logic                 stop_kept;
  rsc_pkg::rsc_state_e  state;
  rsc_pkg::rsc_state_e  next_state;
  rsc_pkg::rsc_resume_e resume;
  logic [7:0]           slow_count;
  logic                 wake;

  // Compares a slow-period count against a limit, used twice.
  function automatic logic count_done(input logic [7:0] count,
                                      input int         limit);
    return count >= 8'(limit - 1);
  endfunction

  // R20 sources held
  // The watchdog pulse is short, so it is held until the next slow
  // tick; the level sources hold for as long as they stay active.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      wdog_hold <= 1'b0;
    end else if (WATCHDOG_OVERFLOW) begin
      wdog_hold <= 1'b1;
    end else if (SLOW_TICK) begin
      wdog_hold <= 1'b0;
    end
  end

  // R05 level sources
  // R09 detector release
  assign pin_hold = ~RESET_PIN_N;

  // R03 four sources merged
  // R04 identical effect
  assign reset_any = pin_hold | wdog_hold | POWER_ON_CLEAR_DETECT |
                     SUPPLY_DROP_DETECT;

  // R19 synchronised release
  rsc_sync u_sync (
    .CLOCK      (CLOCK),
    .RST        (RST),
    .reset_any  (reset_any),
    .slow_tick  (SLOW_TICK),
    .reset_sync (reset_sync)
  );

  // ******************************************************************
  // Release sequencer
  // ******************************************************************
  // Stop entry is only honoured when no wake request is pending.
  // R01 mask keeps stop
  assign wake = INTERRUPT_REQUEST & ~INTERRUPT_MASK_FLAG;

  // Next state choice; reset always wins over any interrupt flag.
  always_comb begin
    next_state = state;
    unique case (state)
      rsc_pkg::RSC_HOLD: begin
        if (!reset_sync) next_state = rsc_pkg::RSC_STOPPED_CLOCK;
      end
      rsc_pkg::RSC_STOPPED_CLOCK: begin
        if (SLOW_TICK && count_done(slow_count, STOP_PERIODS))
          next_state = rsc_pkg::RSC_FETCH_LO;
      end
      rsc_pkg::RSC_FETCH_LO:  next_state = rsc_pkg::RSC_FETCH_HI;
      rsc_pkg::RSC_FETCH_HI:  next_state = rsc_pkg::RSC_RUN;
      rsc_pkg::RSC_RUN: begin
        if (STOP_ENTER && !wake) next_state = rsc_pkg::RSC_STOP_MODE;
      end
      rsc_pkg::RSC_STOP_MODE: begin
        if (wake) next_state = rsc_pkg::RSC_OSC_WAIT;
      end
      rsc_pkg::RSC_OSC_WAIT: begin
        if (SLOW_TICK && count_done(slow_count, OSC_WAIT))
          next_state = rsc_pkg::RSC_RUN;
      end
      default: next_state = rsc_pkg::RSC_HOLD;
    endcase
    if (reset_sync) next_state = rsc_pkg::RSC_HOLD;
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) state <= rsc_pkg::RSC_HOLD;
    else     state <= next_state;
  end

  // R07 stopped-clock count
  // R08 same interval
  // R17 stabilization wait
  // One count serves both waits, which never follow each other directly.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      slow_count <= 8'h00;
    end else if (state != rsc_pkg::RSC_STOPPED_CLOCK &&
                 state != rsc_pkg::RSC_OSC_WAIT) begin
      slow_count <= 8'h00;
    end else if (SLOW_TICK) begin
      slow_count <= slow_count + 8'h01;
    end
  end

  // R02 service decision
  // The decision is latched at wake so later flag changes do not move it.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      resume <= rsc_pkg::RSC_RESUME_NONE;
    end else if (reset_sync) begin
      resume <= rsc_pkg::RSC_RESUME_NONE;
    end else if (state == rsc_pkg::RSC_STOP_MODE && wake) begin
      if (INTERRUPT_ENABLE_FLAG &&
          (!INTERRUPT_PRIORITY_FLAG || IN_SERVICE_PRIORITY_FLAG))
        resume <= rsc_pkg::RSC_RESUME_SERVICE;
      else
        resume <= rsc_pkg::RSC_RESUME_NEXT;
    end else if (state == rsc_pkg::RSC_RUN) begin
      resume <= rsc_pkg::RSC_RESUME_NONE;
    end
  end

  // Resume strobes last exactly one cycle, when the wait ends.
  assign RESUME_SERVICE = state == rsc_pkg::RSC_OSC_WAIT &&
                          next_state == rsc_pkg::RSC_RUN &&
                          resume == rsc_pkg::RSC_RESUME_SERVICE;
  assign RESUME_NEXT    = state == rsc_pkg::RSC_OSC_WAIT &&
                          next_state == rsc_pkg::RSC_RUN &&
                          resume == rsc_pkg::RSC_RESUME_NEXT;

  // ******************************************************************
  // Control outputs
  // ******************************************************************
  // Registered so the pins see no decode glitches.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      CPU_RESET        <= 1'b1;
      CPU_CLOCK_ENABLE <= 1'b0;
      PORTS_HIGH_Z     <= 1'b1;
      IN_STOP          <= 1'b0;
      stop_kept        <= 1'b0;
    end else begin
      CPU_RESET        <= next_state == rsc_pkg::RSC_HOLD ||
                          next_state == rsc_pkg::RSC_STOPPED_CLOCK;
      CPU_CLOCK_ENABLE <= next_state == rsc_pkg::RSC_RUN ||
                          next_state == rsc_pkg::RSC_FETCH_LO ||
                          next_state == rsc_pkg::RSC_FETCH_HI;
      // R06 ports floated
      // R12 ports float too
      PORTS_HIGH_Z     <= next_state == rsc_pkg::RSC_HOLD ||
                          next_state == rsc_pkg::RSC_STOPPED_CLOCK;
      IN_STOP          <= next_state == rsc_pkg::RSC_STOP_MODE ||
                          next_state == rsc_pkg::RSC_OSC_WAIT;
      // R12 reset in stop
      stop_kept        <= reset_sync && (stop_kept || IN_STOP);
    end
  end

  // R11 oscillators stopped
  assign CLOCKS_STOPPED = pin_hold;

  // R14 watchdog self reset
  // R13 detector spared
  // A supply-drop reset leaves the detector and its control alone.
  assign WATCHDOG_RESET        = reset_any;
  assign SUPPLY_DETECTOR_RESET = pin_hold | wdog_hold | POWER_ON_CLEAR_DETECT;

  // R12 stop contents held
  // Only a reset arriving outside stop clears the stop context.
  assign STOP_CONTEXT_CLEAR = reset_sync & ~IN_STOP & ~stop_kept;

  // R04 vector fetch
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      VECTOR_ADDRESS <= `RSC_RESET_VECTOR_LO;
      VECTOR_READ    <= 1'b0;
      PC_LOAD_LO     <= 1'b0;
      PC_LOAD_HI     <= 1'b0;
    end else begin
      VECTOR_ADDRESS <= next_state == rsc_pkg::RSC_FETCH_HI ?
                        `RSC_RESET_VECTOR_HI : `RSC_RESET_VECTOR_LO;
      VECTOR_READ    <= next_state == rsc_pkg::RSC_FETCH_LO ||
                        next_state == rsc_pkg::RSC_FETCH_HI;
      PC_LOAD_LO     <= next_state == rsc_pkg::RSC_FETCH_LO;
      PC_LOAD_HI     <= next_state == rsc_pkg::RSC_FETCH_HI;
    end
  end

  // ******************************************************************
  // Oscillation wait registers
  // ******************************************************************
  // R15 select reset value
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      OSCILLATION_WAIT_SELECT <= `RSC_WAIT_SELECT_RESET;
    end else if (reset_sync) begin
      OSCILLATION_WAIT_SELECT <= `RSC_WAIT_SELECT_RESET;
    end else if (WAIT_SELECT_WRITE) begin
      OSCILLATION_WAIT_SELECT <= WAIT_SELECT_WRITE_DATA;
    end
  end

  // R16 status reset value
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      OSCILLATION_WAIT_STATUS <= `RSC_WAIT_STATUS_RESET;
    end else if (reset_sync) begin
      OSCILLATION_WAIT_STATUS <= `RSC_WAIT_STATUS_RESET;
    end else if (state == rsc_pkg::RSC_OSC_WAIT) begin
      OSCILLATION_WAIT_STATUS <= slow_count;
    end
  end

  // ******************************************************************
  // Reset cause flags
  // ******************************************************************
  // R18 cause recording
  // A set wins over a read clear in the same cycle; pin and POWER_ON_CLEAR_DETECTOR clear.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      RESET_CAUSE_FLAGS <= `RSC_CAUSE_RESET;
    end else if (pin_hold | POWER_ON_CLEAR_DETECT) begin
      RESET_CAUSE_FLAGS <= `RSC_CAUSE_RESET;
    end else begin
      if (wdog_hold)
        RESET_CAUSE_FLAGS[`RSC_CAUSE_WDOG_BIT] <= 1'b1;
      else if (CAUSE_READ)
        RESET_CAUSE_FLAGS[`RSC_CAUSE_WDOG_BIT] <= 1'b0;
      if (SUPPLY_DROP_DETECT)
        RESET_CAUSE_FLAGS[`RSC_CAUSE_SUPPLY_BIT] <= 1'b1;
      else if (CAUSE_READ)
        RESET_CAUSE_FLAGS[`RSC_CAUSE_SUPPLY_BIT] <= 1'b0;
    end
  end

endmodule

// ===== verif/rsc_properties.sv
// Concurrent checks on the ports of the reset and stop release controller.
module rsc_properties #(
  parameter int STOP_PERIODS = 21,
  parameter int OSC_WAIT     = 64
) (
  input wire logic        CLOCK,
  input wire logic        RST,
  input wire logic        SLOW_TICK,
  input wire logic        RESET_PIN_N,
  input wire logic        WATCHDOG_OVERFLOW,
  input wire logic        POWER_ON_CLEAR_DETECT,
  input wire logic        SUPPLY_DROP_DETECT,
  input wire logic        INTERRUPT_REQUEST,
  input wire logic        INTERRUPT_MASK_FLAG,
  input wire logic        INTERRUPT_PRIORITY_FLAG,
  input wire logic        INTERRUPT_ENABLE_FLAG,
  input wire logic        IN_SERVICE_PRIORITY_FLAG,
  input wire logic        CPU_RESET,
  input wire logic        CLOCKS_STOPPED,
  input wire logic        PORTS_HIGH_Z,
  input wire logic        WATCHDOG_RESET,
  input wire logic        SUPPLY_DETECTOR_RESET,
  input wire logic        STOP_CONTEXT_CLEAR,
  input wire logic [15:0] VECTOR_ADDRESS,
  input wire logic        PC_LOAD_LO,
  input wire logic        PC_LOAD_HI,
  input wire logic        IN_STOP,
  input wire logic        RESUME_SERVICE,
  input wire logic        RESUME_NEXT
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Helper logic
  // ****************
  int unsigned n_tick;
  logic        src_on;
  logic        wake;

  default clocking @(posedge CLOCK);
  endclocking
  default disable iff (RST);

  // Any source still asserting; a pulse counts before it is latched.
  assign src_on = !RESET_PIN_N || WATCHDOG_OVERFLOW || WATCHDOG_RESET
                  || POWER_ON_CLEAR_DETECT || SUPPLY_DROP_DETECT;
  assign wake = IN_STOP && INTERRUPT_REQUEST && !INTERRUPT_MASK_FLAG;

  // Slow ticks seen while reset is held after the last source let go.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      n_tick <= 0;
    end else if (src_on || !CPU_RESET) begin
      n_tick <= 0;
    end else if (SLOW_TICK) begin
      n_tick <= n_tick + 1;
    end
  end

  // ****************
  // Properties
  // ****************
  sequence s_lo_byte;
    PC_LOAD_LO && VECTOR_ADDRESS == 16'h0000;
  endsequence
  sequence s_hi_byte;
    PC_LOAD_HI && VECTOR_ADDRESS == 16'h0001;
  endsequence
  sequence s_quiet;
    !(RESUME_SERVICE || RESUME_NEXT) [*8];
  endsequence

  a_vector_fetch_pair: assert property (
    PC_LOAD_LO |-> s_lo_byte ##1 s_hi_byte)
    else $error("vector bytes fetched out of order");
  a_release_tick_count: assert property (
    $fell(CPU_RESET) |-> n_tick inside {[STOP_PERIODS:STOP_PERIODS+3]})
    else $error("stopped clock interval has the wrong length");
  a_pin_stops_clocks: assert property (
    !RESET_PIN_N |-> CLOCKS_STOPPED)
    else $error("clocks run while the pin is low");
  a_pin_forces_reset: assert property (
    !RESET_PIN_N [*3] |-> CPU_RESET && PORTS_HIGH_Z)
    else $error("low pin does not hold reset");
  a_supply_spares_detector: assert property (
    $rose(SUPPLY_DROP_DETECT) && RESET_PIN_N && !POWER_ON_CLEAR_DETECT
    && !WATCHDOG_OVERFLOW && !CPU_RESET |-> !SUPPLY_DETECTOR_RESET)
    else $error("supply drop resets its own detector");
  a_wdog_resets_itself: assert property (
    WATCHDOG_OVERFLOW |-> ##[0:1] WATCHDOG_RESET)
    else $error("overflow does not reset the watchdog");
  a_resume_choice: assert property (
    RESUME_SERVICE || RESUME_NEXT |-> RESUME_SERVICE != RESUME_NEXT
    && RESUME_SERVICE == (INTERRUPT_ENABLE_FLAG
    && (!INTERRUPT_PRIORITY_FLAG || IN_SERVICE_PRIORITY_FLAG)))
    else $error("wrong resume decision");
  a_masked_keeps_stop: assert property (
    IN_STOP && INTERRUPT_MASK_FLAG && !src_on && !CPU_RESET
    && !RESUME_SERVICE && !RESUME_NEXT |=> IN_STOP)
    else $error("masked request left stop mode");
  a_wake_waits: assert property (
    $rose(wake) |-> s_quiet ##[1:1000] (RESUME_SERVICE || RESUME_NEXT))
    else $error("resume without the stabilization wait");
  a_stop_context_kept: assert property (
    IN_STOP && !RESET_PIN_N |=> !STOP_CONTEXT_CLEAR [*8])
    else $error("stop contents cleared in stop mode");
endmodule

bind rsc_reset_control rsc_properties #(
  .STOP_PERIODS(STOP_PERIODS),
  .OSC_WAIT    (OSC_WAIT)
) chk_u (.*);

// ===== verif/rsc_partner.sv
// Model of the reset pin driver, the detectors and the slow oscillator.
`include "rsc_params.svh"
module rsc_partner #(
  parameter int TICK_DIV = 8
) (
  input  wire logic       CLOCK,
  input  wire logic [3:0] src_req,
  output logic            SLOW_TICK,
  output logic            RESET_PIN_N,
  output logic            WATCHDOG_OVERFLOW,
  output logic            POWER_ON_CLEAR_DETECT,
  output logic            SUPPLY_DROP_DETECT
);
  timeunit 1ns;
  timeprecision 1ps;
  int   n_div   = 0;
  int   n_low   = 0;
  logic wd_last = 1'b0;

  initial begin
    {SLOW_TICK, WATCHDOG_OVERFLOW} = 2'b00;
    {POWER_ON_CLEAR_DETECT, SUPPLY_DROP_DETECT} = 2'b00;
    RESET_PIN_N = 1'b1;
  end

  // Slow tick runs free; the overflow is a pulse on each new request.
  always @(posedge CLOCK) begin
    n_div <= (n_div == TICK_DIV - 1) ? 0 : n_div + 1;
    SLOW_TICK <= #1 (n_div == TICK_DIV - 1);
    WATCHDOG_OVERFLOW <= #1 src_req[1] && !wd_last;
    wd_last <= src_req[1];
    POWER_ON_CLEAR_DETECT <= #1 src_req[2];
    SUPPLY_DROP_DETECT <= #1 src_req[3];
  end

  // least pin width
  // Once asked, the pin stays low for the whole least pulse width.
  always @(posedge CLOCK) begin
    if (src_req[0]) begin
      n_low <= 1;
    end else if (n_low != 0 && n_low < `RSC_MIN_PIN_CYCLES) begin
      n_low <= n_low + 1;
    end else begin
      n_low <= 0;
    end
    RESET_PIN_N <= #1 !(src_req[0] || n_low != 0);
  end
endmodule

// ===== verif/tb_reset_and_stop_release_control.sv
// Self-checking bench for the reset and stop release controller.
module tb_reset_and_stop_release_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV    = 8;
  localparam int WAIT_N = 4;
  logic CLOCK, RST, SLOW_TICK, RESET_PIN_N, WATCHDOG_OVERFLOW;
  logic POWER_ON_CLEAR_DETECT, SUPPLY_DROP_DETECT, STOP_ENTER;
  logic INTERRUPT_REQUEST, INTERRUPT_MASK_FLAG, INTERRUPT_PRIORITY_FLAG;
  logic INTERRUPT_ENABLE_FLAG, IN_SERVICE_PRIORITY_FLAG, CAUSE_READ;
  logic WAIT_SELECT_WRITE, CPU_RESET, CPU_CLOCK_ENABLE, CLOCKS_STOPPED;
  logic PORTS_HIGH_Z, WATCHDOG_RESET, SUPPLY_DETECTOR_RESET, IN_STOP;
  logic STOP_CONTEXT_CLEAR, VECTOR_READ, PC_LOAD_LO, PC_LOAD_HI;
  logic RESUME_SERVICE, RESUME_NEXT;
  logic [7:0]  WAIT_SELECT_WRITE_DATA, OSCILLATION_WAIT_SELECT;
  logic [7:0]  OSCILLATION_WAIT_STATUS, RESET_CAUSE_FLAGS;
  logic [15:0] VECTOR_ADDRESS;
  logic [3:0]  src_req;
  int          n_mismatch  = 0;
  int          checks_done = 0;
  int          n_cyc       = 0;
  int          src_seq[6]  = '{1, 3, 0, 3, 2, 1};
  logic [7:0]  cause_exp[6] = '{8'h10, 8'h11, 8'h00, 8'h01, 8'h00, 8'h10};

  rsc_reset_control #(.STOP_PERIODS(21), .OSC_WAIT(WAIT_N)) dut_u (.*);
  rsc_partner #(.TICK_DIV(DIV)) part_u (.*);

  initial begin
    CLOCK = 1'b0;
    forever #20 CLOCK = ~CLOCK;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Inputs always change one nanosecond after the rising edge.
  task automatic tick(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask

  // Waits for the vector fetch that ends a reset and checks both bytes.
  task automatic wait_fetch();
    int n;
    n = 0;
    while (PC_LOAD_LO !== 1'b1 && n < 3000) begin
      tick(1);
      n++;
    end
    check(VECTOR_ADDRESS, 16'h0000);
    check(VECTOR_READ, 1'b1);
    tick(1);
    check(VECTOR_ADDRESS, 16'h0001);
    check(VECTOR_READ, 1'b1);
    tick(2);
    check(CPU_CLOCK_ENABLE, 1'b1);
    check(PORTS_HIGH_Z, 1'b0);
  endtask

  // Enters stop, wakes it by an unmasked request, checks the outcome.
  task automatic stop_wake(input logic [2:0] f, input logic svc);
    int n;
    {INTERRUPT_PRIORITY_FLAG, INTERRUPT_ENABLE_FLAG} = f[2:1];
    IN_SERVICE_PRIORITY_FLAG = f[0];
    STOP_ENTER = 1'b1;
    tick(1);
    STOP_ENTER = 1'b0;
    tick(3);
    check(IN_STOP, 1'b1);
    INTERRUPT_REQUEST = 1'b1;
    n = 0;
    // Strobes are looked at mid-cycle, clear of the slow tick's change.
    while (RESUME_SERVICE !== 1'b1 && RESUME_NEXT !== 1'b1 && n < 500) begin
      @(negedge CLOCK);
      n++;
    end
    check(RESUME_SERVICE, svc);
    check(RESUME_NEXT, !svc);
    check(n >= (WAIT_N - 1) * DIV, 1'b1);
    tick(1);
    INTERRUPT_REQUEST = 1'b0;
    tick(1);
  endtask

  // A hang is cut short here and counted as a mismatch.
  always @(posedge CLOCK) begin
    n_cyc <= n_cyc + 1;
    if (n_cyc == 20000) begin
      n_mismatch++;
      conclude();
    end
  end

  initial begin
    RST = 1'b1;
    src_req = 4'h0;
    {STOP_ENTER, INTERRUPT_REQUEST, CAUSE_READ, WAIT_SELECT_WRITE} = 4'h0;
    {INTERRUPT_PRIORITY_FLAG, INTERRUPT_ENABLE_FLAG} = 2'b00;
    {IN_SERVICE_PRIORITY_FLAG, INTERRUPT_MASK_FLAG} = 2'b00;
    WAIT_SELECT_WRITE_DATA = 8'h00;
    tick(12);
    RST = 1'b0;
    check(OSCILLATION_WAIT_SELECT, 8'h05);
    check(OSCILLATION_WAIT_STATUS, 8'h00);
    check(RESET_CAUSE_FLAGS, 8'h00);
    check(PORTS_HIGH_Z, 1'b1);
    wait_fetch();
    $display("Test of reset values done");
    // Every source in turn; flags build up until a pin or POWER_ON_CLEAR_DETECT reset clears them.
    for (int i = 0; i < 6; i++) begin
      src_req[src_seq[i]] = 1'b1;
      tick(5);
      check(CPU_RESET, 1'b1);
      case (src_seq[i])
        0: check(CLOCKS_STOPPED, 1'b1);
        3: check(SUPPLY_DETECTOR_RESET, 1'b0);
        default: check(PORTS_HIGH_Z, 1'b1);
      endcase
      check(STOP_CONTEXT_CLEAR, 1'b1);
      tick(20);
      src_req = 4'h0;
      wait_fetch();
      check(RESET_CAUSE_FLAGS, cause_exp[i]);
    end
    CAUSE_READ = 1'b1;
    tick(1);
    CAUSE_READ = 1'b0;
    tick(2);
    check(RESET_CAUSE_FLAGS, 8'h00);
    $display("Test of reset sources done");
    for (int i = 0; i < 8; i++) begin
      stop_wake(i[2:0], i[1] && (!i[2] || i[0]));
    end
    $display("Test of stop release done");
    INTERRUPT_MASK_FLAG = 1'b1;
    INTERRUPT_REQUEST = 1'b1;
    WAIT_SELECT_WRITE_DATA = 8'h03;
    WAIT_SELECT_WRITE = 1'b1;
    tick(1);
    WAIT_SELECT_WRITE = 1'b0;
    STOP_ENTER = 1'b1;
    tick(1);
    STOP_ENTER = 1'b0;
    tick(40);
    check(IN_STOP, 1'b1);
    check(OSCILLATION_WAIT_SELECT, 8'h03);
    src_req[0] = 1'b1;
    tick(6);
    check(STOP_CONTEXT_CLEAR, 1'b0);
    check(PORTS_HIGH_Z, 1'b1);
    check(CPU_RESET, 1'b1);
    src_req[0] = 1'b0;
    {INTERRUPT_REQUEST, INTERRUPT_MASK_FLAG} = 2'b00;
    wait_fetch();
    check(OSCILLATION_WAIT_SELECT, 8'h05);
    $display("Test of pin reset in stop done");
    conclude();
  end
endmodule
